/* File: rtl/irbaud_pkg.sv */
// constants and helper functions for the infrared serial baud and pulse block
// assumes a 32-bit axi4-lite master and one reference clock
package irbaud_pkg;
  // register byte addresses
  localparam logic [7:0] RATE_SELECT_ADDR = 8'h00;
  localparam logic [7:0] IR_CONTROL_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  // serial_rate_select field positions
  localparam int RATE_SOURCE_BIT = 6;
  localparam int PRESCALE_LSB = 4;
  localparam int RATE_DIV_LSB = 0;
  // infrared_control field positions
  localparam int NARROW_PULSE_LSB = 1;
  localparam int IR_ENABLE_BIT = 0;
  // writable bits and reset values
  localparam logic [7:0] RATE_SELECT_MASK = 8'h77;
  localparam logic [7:0] IR_CONTROL_MASK = 8'h07;
  localparam logic [7:0] RATE_SELECT_RESET = 8'h00;
  localparam logic [7:0] IR_CONTROL_RESET = 8'h00;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // sampling ticks per bit time
  localparam logic [3:0] TICKS_PER_BIT_LAST = 4'hf;
  localparam logic [4:0] TICKS_PER_BIT = 5'h10;
  // narrow pulse codes
  localparam logic [1:0] PULSE_3_16 = 2'h0;
  localparam logic [1:0] PULSE_1_16 = 2'h1;
  localparam logic [12:0] PULSE_MIN = 13'h0001;

  // prescaler divisor from its two-bit code
  function automatic logic [3:0] prescale_divisor(input logic [1:0] code);
    case (code)
      2'h0: prescale_divisor = 4'h1;
      2'h1: prescale_divisor = 4'h3;
      2'h2: prescale_divisor = 4'h4;
      default: prescale_divisor = 4'hd;
    endcase
  endfunction

  // binary rate divisor, two to the power of the code
  function automatic logic [7:0] rate_divisor(input logic [2:0] code);
    rate_divisor = 8'h01 << code;
  endfunction
endpackage

/* File: rtl/baud_tick_if.sv */
// timing signals passed from the baud generator to the infrared shaper
// all signals are synchronous to the reference clock
interface baud_tick_if;
  logic src_tick;
  logic tick16;
  logic bit_start;
  logic [12:0] pulse_len;
  modport gen (output src_tick, output tick16, output bit_start, output pulse_len);
  modport shaper (input src_tick, input tick16, input bit_start, input pulse_len);
endinterface

/* File: rtl/ir_pulse_shaper.sv */
// infrared encoder and decoder driven by the common baud timing
// assumes rx input already passed a two-flop synchroniser
module ir_pulse_shaper (
  input wire logic i_clk,
  input wire logic i_rst_b,
  baud_tick_if.shaper tick,
  input wire logic i_enable,
  input wire logic i_tx_data,
  input wire logic i_rx_sync,
  output logic o_ir_tx,
  output logic o_rx_dec
);
  typedef struct packed {
    logic rx_prev;
    logic [12:0] pulse_cnt;
    logic [4:0] stretch_cnt;
    logic ir_tx;
    logic rx_dec;
  } shaper_state_t;

  shaper_state_t state_reg;
  shaper_state_t state_next;

  localparam logic [12:0] PULSE_MIN_L = irbaud_pkg::PULSE_MIN;

  // encoder pulses low bits, decoder stretches each pulse to a bit time
  always_comb begin
    state_next = state_reg;
    state_next.rx_prev = i_rx_sync;
    if (!i_enable) begin
      state_next.pulse_cnt = '0;
      state_next.stretch_cnt = '0;
      state_next.ir_tx = i_tx_data;
      state_next.rx_dec = i_rx_sync;
    end else begin
      // no pulse running means light off; also drops a line copy left high at enable
      if (tick.bit_start && !i_tx_data) begin
        state_next.pulse_cnt = tick.pulse_len;
        state_next.ir_tx = 1'b1;
      end else if (tick.bit_start) begin
        state_next.ir_tx = 1'b0;
      end else if (tick.src_tick && state_reg.pulse_cnt != '0) begin
        state_next.pulse_cnt = state_reg.pulse_cnt - 13'h0001;
        state_next.ir_tx = (state_reg.pulse_cnt != PULSE_MIN_L);
      end else if (state_reg.pulse_cnt == '0) begin
        state_next.ir_tx = 1'b0;
      end
      // falling edge of the received light pulse starts a zero bit
      if (state_reg.rx_prev && !i_rx_sync) begin
        state_next.stretch_cnt = irbaud_pkg::TICKS_PER_BIT;
        state_next.rx_dec = 1'b0;
      end else if (tick.tick16 && state_reg.stretch_cnt != '0) begin
        state_next.stretch_cnt = state_reg.stretch_cnt - 5'h01;
        state_next.rx_dec = (state_reg.stretch_cnt == 5'h01);
      end
    end
  end

  // idle levels: line high when disabled, light off when enabled
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= '{rx_prev: 1'b1, pulse_cnt: 13'h0000, stretch_cnt: 5'h00, ir_tx: 1'b1, rx_dec: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_ir_tx = state_reg.ir_tx;
  assign o_rx_dec = state_reg.rx_dec;
endmodule

/* File: rtl/ir_serial_baud_and_pulse_ctrl.sv */
// baud rate generator and infrared pulse control with an axi4-lite register slave
// assumes the crystal-derived clock is slower than half the reference clock
// assumes the transmit stream comes from logic on the reference clock, so it is not synchronised
// assumes the infrared receiver pin reads low while light falls on it
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
module ir_serial_baud_and_pulse_ctrl (
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  input wire logic I_CRYSTAL_DERIVED_CLK,
  input wire logic I_TX_DATA,
  input wire logic I_IR_RXD,
  output logic O_IR_TXD,
  output logic O_RXD_DEC,
  output logic O_BAUD_TICK16,
  output logic O_BIT_START,
  input wire logic [7:0] I_S_AXI_AWADDR,
  input wire logic I_S_AXI_AWVALID,
  output logic O_S_AXI_AWREADY,
  input wire logic [31:0] I_S_AXI_WDATA,
  input wire logic [3:0] I_S_AXI_WSTRB,
  input wire logic I_S_AXI_WVALID,
  output logic O_S_AXI_WREADY,
  output logic [1:0] O_S_AXI_BRESP,
  output logic O_S_AXI_BVALID,
  input wire logic I_S_AXI_BREADY,
  input wire logic [7:0] I_S_AXI_ARADDR,
  input wire logic I_S_AXI_ARVALID,
  output logic O_S_AXI_ARREADY,
  output logic [31:0] O_S_AXI_RDATA,
  output logic [1:0] O_S_AXI_RRESP,
  output logic O_S_AXI_RVALID,
  input wire logic I_S_AXI_RREADY
);
  typedef struct packed {
    // bus slave
    logic awready;
    logic wready;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;

    // control registers
    logic [7:0] rate_select;
    logic [7:0] ir_control;

    // pin synchronisers
    logic xtal_s1;
    logic xtal_s2;
    logic xtal_s3;
    logic rx_s1;
    logic rx_s2;

    // baud generator
    logic src_tick;
    logic [3:0] pre_cnt;
    logic [6:0] div_cnt;
    logic [3:0] phase;
    logic tick16;
    logic bit_start;
  } top_state_t;

  localparam top_state_t STATE_RESET = '{
    awready: 1'b1,
    wready: 1'b1,
    aw_have: 1'b0,
    aw_addr: 8'h00,
    w_have: 1'b0,
    w_data: 8'h00,
    w_lane0: 1'b0,
    bvalid: 1'b0,
    bresp: 2'h0,
    arready: 1'b1,
    rvalid: 1'b0,
    rdata: 8'h00,
    rresp: 2'h0,
    rate_select: irbaud_pkg::RATE_SELECT_RESET,
    ir_control: irbaud_pkg::IR_CONTROL_RESET,
    xtal_s1: 1'b0,
    xtal_s2: 1'b0,
    xtal_s3: 1'b0,
    rx_s1: 1'b1,
    rx_s2: 1'b1,
    src_tick: 1'b0,
    pre_cnt: 4'h0,
    div_cnt: 7'h00,
    phase: 4'h0,
    tick16: 1'b0,
    bit_start: 1'b0
  };

  top_state_t state_reg;
  top_state_t state_next;

  // timing bundle towards the infrared shaper
  baud_tick_if tick_bus ();

  // decoded fields of the two control registers
  logic rate_source;
  logic [1:0] prescale_code;
  logic [2:0] rate_divider_code;
  logic [1:0] narrow_pulse_code;
  logic infrared_enable;

  // divisors and pulse length, counted in source ticks
  logic [3:0] prescale_div;
  logic [7:0] rate_div;
  logic [12:0] unit_len;
  logic [12:0] pulse_len;

  // shaper outputs, already registered inside it
  logic ir_tx_int;
  logic rx_dec_int;

  // field extraction from the control registers
  assign rate_source = state_reg.rate_select[irbaud_pkg::RATE_SOURCE_BIT];
  assign prescale_code = state_reg.rate_select[irbaud_pkg::PRESCALE_LSB +: 2];
  assign rate_divider_code = state_reg.rate_select[irbaud_pkg::RATE_DIV_LSB +: 3];
  assign narrow_pulse_code = state_reg.ir_control[irbaud_pkg::NARROW_PULSE_LSB +: 2];
  assign infrared_enable = state_reg.ir_control[irbaud_pkg::IR_ENABLE_BIT];
  assign prescale_div = irbaud_pkg::prescale_divisor(prescale_code);
  assign rate_div = irbaud_pkg::rate_divisor(rate_divider_code);

  // one sampling tick lasts prescale times rate source ticks
  // both factors widened first, so the product cannot wrap at eight bits
  assign unit_len = 13'(prescale_div) * 13'(rate_div);

  // pulse width in source ticks; 1/32 rounds down, never below one tick
  // the 3/16 width of the slowest setting still fits thirteen bits
  always_comb begin
    case (narrow_pulse_code)
      irbaud_pkg::PULSE_3_16: pulse_len = 13'(unit_len * 13'h0003);
      irbaud_pkg::PULSE_1_16: pulse_len = unit_len;
      default: pulse_len = (unit_len == irbaud_pkg::PULSE_MIN) ? irbaud_pkg::PULSE_MIN : (unit_len >> 1);
    endcase
  end

  // timing signals towards the shaper, registered except pulse_len, which is decoded from the registers
  assign tick_bus.src_tick = state_reg.src_tick;
  assign tick_bus.tick16 = state_reg.tick16;
  assign tick_bus.bit_start = state_reg.bit_start;
  assign tick_bus.pulse_len = pulse_len;

  // register read mux, narrow values in the low byte
  function automatic logic [7:0] read_value(input logic [7:0] addr, input top_state_t s, input logic tx,
                                            input logic rx);
    case (addr)
      irbaud_pkg::RATE_SELECT_ADDR: read_value = s.rate_select;
      irbaud_pkg::IR_CONTROL_ADDR: read_value = s.ir_control;
      irbaud_pkg::STATUS_ADDR: read_value = {s.phase, 2'h0, rx, tx};
      default: read_value = 8'h00;
    endcase
  endfunction

  // address decode shared by the write commit and the read response
  function automatic logic is_writable(input logic [7:0] addr);
    is_writable = (addr == irbaud_pkg::RATE_SELECT_ADDR) || (addr == irbaud_pkg::IR_CONTROL_ADDR);
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = is_writable(addr) || (addr == irbaud_pkg::STATUS_ADDR);
  endfunction

  // next-state logic: bus slave, synchronisers and divider chain
  always_comb begin
    state_next = state_reg;

    // address and data are taken in either order, answer follows both
    if (I_S_AXI_AWVALID && state_reg.awready) begin
      state_next.aw_have = 1'b1;
      state_next.aw_addr = I_S_AXI_AWADDR;
    end
    if (I_S_AXI_WVALID && state_reg.wready) begin
      state_next.w_have = 1'b1;
      state_next.w_data = I_S_AXI_WDATA[7:0];
      state_next.w_lane0 = I_S_AXI_WSTRB[0];
    end
    // the response leaves once the master has taken it
    if (state_reg.bvalid && I_S_AXI_BREADY) begin
      state_next.bvalid = 1'b0;
    end
    // commit one cycle after both halves are held; a pending response holds off the next
    if (state_reg.aw_have && state_reg.w_have && !state_reg.bvalid) begin
      state_next.aw_have = 1'b0;
      state_next.w_have = 1'b0;
      state_next.bvalid = 1'b1;
      // status and unmapped writes answer with an error and change nothing
      state_next.bresp = is_writable(state_reg.aw_addr) ? irbaud_pkg::RESP_OKAY : irbaud_pkg::RESP_SLVERR;
      // only byte lane 0 carries register bits
      if (state_reg.w_lane0 && state_reg.aw_addr == irbaud_pkg::RATE_SELECT_ADDR) begin
        state_next.rate_select = state_reg.w_data & irbaud_pkg::RATE_SELECT_MASK;
      end
      if (state_reg.w_lane0 && state_reg.aw_addr == irbaud_pkg::IR_CONTROL_ADDR) begin
        state_next.ir_control = state_reg.w_data & irbaud_pkg::IR_CONTROL_MASK;
      end
    end
    // readies drop while a write is held, so one write at a time
    state_next.awready = !state_next.aw_have && !state_next.bvalid;
    state_next.wready = !state_next.w_have && !state_next.bvalid;

    // read: one beat at a time, answer the cycle after acceptance
    if (state_reg.rvalid && I_S_AXI_RREADY) begin
      state_next.rvalid = 1'b0;
    end
    // data captured at acceptance, so a write landing later cannot tear them
    if (I_S_AXI_ARVALID && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = read_value(I_S_AXI_ARADDR, state_reg, ir_tx_int, rx_dec_int);
      state_next.rresp = is_mapped(I_S_AXI_ARADDR) ? irbaud_pkg::RESP_OKAY : irbaud_pkg::RESP_SLVERR;
    end
    state_next.arready = !state_next.rvalid;

    // two flops before any logic looks at the crystal or receiver pin
    state_next.xtal_s1 = I_CRYSTAL_DERIVED_CLK;
    state_next.xtal_s2 = state_reg.xtal_s1;
    state_next.xtal_s3 = state_reg.xtal_s2;
    state_next.rx_s1 = I_IR_RXD;
    state_next.rx_s2 = state_reg.rx_s1;

    // source tick: every cycle or each rising edge of the crystal clock
    // the crystal edge shows three cycles late, which only shifts the tick phase
    state_next.src_tick = rate_source ? 1'b1 : (state_reg.xtal_s2 && !state_reg.xtal_s3);

    // prescaler then binary divider; output is the sixteen-times tick
    state_next.tick16 = 1'b0;
    state_next.bit_start = 1'b0;
    if (state_reg.src_tick) begin
      if (state_reg.pre_cnt >= prescale_div - 4'h1) begin
        state_next.pre_cnt = 4'h0;
        if ({1'b0, state_reg.div_cnt} >= rate_div - 8'h01) begin
          state_next.div_cnt = 7'h00;
          state_next.tick16 = 1'b1;
        end else begin
          state_next.div_cnt = state_reg.div_cnt + 7'h01;
        end
      end else begin
        state_next.pre_cnt = state_reg.pre_cnt + 4'h1;
      end
    end

    // bit phase counts sixteen ticks; its bit start drives the encoder and O_BIT_START, the decoder keeps its own count
    if (state_reg.tick16) begin
      state_next.phase = state_reg.phase + 4'h1;
      state_next.bit_start = (state_reg.phase == irbaud_pkg::TICKS_PER_BIT_LAST);
    end
  end

  // single register stage for all state; reset clears every field except the three readies and the rx synchroniser, which load one
  // reset values are constants only, so the asynchronous branch stays clean
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // infrared encoder and decoder share the same tick as the serial logic
  ir_pulse_shaper u_shaper (
    .i_clk(I_REF_CLK),
    .i_rst_b(I_RST_B),
    .tick(tick_bus.shaper),
    .i_enable(infrared_enable),
    .i_tx_data(I_TX_DATA),
    .i_rx_sync(state_reg.rx_s2),
    .o_ir_tx(ir_tx_int),
    .o_rx_dec(rx_dec_int)
  );

  // outputs straight from flip-flops
  assign O_IR_TXD = ir_tx_int;
  assign O_RXD_DEC = rx_dec_int;
  assign O_BAUD_TICK16 = state_reg.tick16;
  assign O_BIT_START = state_reg.bit_start;

  // bus handshake, response and read data outputs, each a field of the state register; upper read data bits tied to zero
  assign O_S_AXI_AWREADY = state_reg.awready;
  assign O_S_AXI_WREADY = state_reg.wready;
  assign O_S_AXI_BVALID = state_reg.bvalid;
  assign O_S_AXI_BRESP = state_reg.bresp;
  assign O_S_AXI_ARREADY = state_reg.arready;
  assign O_S_AXI_RVALID = state_reg.rvalid;
  assign O_S_AXI_RRESP = state_reg.rresp;
  assign O_S_AXI_RDATA = {24'h00_0000, state_reg.rdata};
endmodule

/* File: tb/ir_far_side.sv */
// far-side optics model: crystal-derived clock and infrared receiver pin
// assumes the bench raises i_send once for every received light pulse
module ir_far_side (
  input wire logic i_send,
  output logic o_xtal,
  output logic o_ir_rxd
);
  timeunit 1ns;
  timeprecision 100ps;
  // oscillator runs free, 40 ns period, offset from the bench clock edges
  initial begin
    o_xtal = 1'b0;
    #1;
    forever #20 o_xtal = ~o_xtal;
  end
  // receiver idles high with no light; one pulse is 12 ns low, three samples
  initial o_ir_rxd = 1'b1;
  always @(posedge i_send) begin
    #1 o_ir_rxd = 1'b0;
    #12 o_ir_rxd = 1'b1;
  end
endmodule

/* File: tb/ir_baud_asserts.sv */
// bus handshake and infrared output checks for the baud and pulse block
// assumes it is bound to the top module and sees its ports only
module ir_baud_asserts (
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  input wire logic I_TX_DATA,
  input wire logic O_IR_TXD,
  input wire logic O_BIT_START,
  input wire logic [7:0] I_S_AXI_AWADDR,
  input wire logic I_S_AXI_AWVALID,
  input wire logic O_S_AXI_AWREADY,
  input wire logic [31:0] I_S_AXI_WDATA,
  input wire logic [3:0] I_S_AXI_WSTRB,
  input wire logic I_S_AXI_WVALID,
  input wire logic O_S_AXI_WREADY,
  input wire logic [1:0] O_S_AXI_BRESP,
  input wire logic O_S_AXI_BVALID,
  input wire logic I_S_AXI_BREADY,
  input wire logic I_S_AXI_ARVALID,
  input wire logic O_S_AXI_ARREADY,
  input wire logic [31:0] O_S_AXI_RDATA,
  input wire logic O_S_AXI_RVALID,
  input wire logic I_S_AXI_RREADY
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] a_q;
  logic en_q;
  wire logic aw_w = I_S_AXI_AWVALID && O_S_AXI_AWREADY && I_S_AXI_WVALID && O_S_AXI_WREADY;
  wire logic map_ok = a_q == irbaud_pkg::RATE_SELECT_ADDR || a_q == irbaud_pkg::IR_CONTROL_ADDR;
  default clocking dc @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);
  // shadow of address and enable; the enable shadow tracks only same-cycle address and data
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      a_q <= 8'h00;
      en_q <= 1'b0;
    end else begin
      if (I_S_AXI_AWVALID && O_S_AXI_AWREADY) a_q <= I_S_AXI_AWADDR;
      if (aw_w && I_S_AXI_AWADDR == irbaud_pkg::IR_CONTROL_ADDR && I_S_AXI_WSTRB[0]) en_q <= I_S_AXI_WDATA[0];
    end
  end
  wr_latency_a: assert property (aw_w |=> !O_S_AXI_BVALID ##1 O_S_AXI_BVALID)
    else $error("write response not two cycles after accept");
  bresp_hold_a: assert property (O_S_AXI_BVALID && !I_S_AXI_BREADY |=> O_S_AXI_BVALID && $stable(O_S_AXI_BRESP))
    else $error("write response dropped early");
  wr_block_a: assert property (O_S_AXI_BVALID |-> !O_S_AXI_AWREADY && !O_S_AXI_WREADY)
    else $error("write accepted while response pending");
  wr_resp_a: assert property ($rose(O_S_AXI_BVALID) |->
    O_S_AXI_BRESP == (map_ok ? irbaud_pkg::RESP_OKAY : irbaud_pkg::RESP_SLVERR))
    else $error("write response code wrong");
  rd_latency_a: assert property (I_S_AXI_ARVALID && O_S_AXI_ARREADY |=> O_S_AXI_RVALID && O_S_AXI_RDATA[31:8] == 24'h00_0000)
    else $error("read data late or upper bits set");
  rdata_hold_a: assert property (O_S_AXI_RVALID && !I_S_AXI_RREADY |=> O_S_AXI_RVALID && $stable(O_S_AXI_RDATA))
    else $error("read data dropped early");
  rd_block_a: assert property (O_S_AXI_RVALID |-> !O_S_AXI_ARREADY)
    else $error("read accepted while data pending");
  // two cycles of slack: register lands one edge after the shadow, output one more
  ir_copy_a: assert property (!(en_q || $past(en_q) || $past(en_q, 2)) |-> O_IR_TXD == $past(I_TX_DATA))
    else $error("infrared off but transmit pin not a copy");
  ir_rise_a: assert property (en_q && $past(en_q) && $past(en_q, 2) && $rose(O_IR_TXD) |->
    $past(O_BIT_START) && !$past(I_TX_DATA))
    else $error("infrared pulse without a zero bit start");
  cover property (aw_w);
  cover property (O_S_AXI_RVALID && I_S_AXI_RREADY);
  cover property (en_q && $rose(O_IR_TXD));
endmodule

bind ir_serial_baud_and_pulse_ctrl ir_baud_asserts u_asserts (
  .I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B), .I_TX_DATA(I_TX_DATA), .O_IR_TXD(O_IR_TXD),
  .O_BIT_START(O_BIT_START), .I_S_AXI_AWADDR(I_S_AXI_AWADDR), .I_S_AXI_AWVALID(I_S_AXI_AWVALID),
  .O_S_AXI_AWREADY(O_S_AXI_AWREADY), .I_S_AXI_WDATA(I_S_AXI_WDATA), .I_S_AXI_WSTRB(I_S_AXI_WSTRB),
  .I_S_AXI_WVALID(I_S_AXI_WVALID), .O_S_AXI_WREADY(O_S_AXI_WREADY), .O_S_AXI_BRESP(O_S_AXI_BRESP),
  .O_S_AXI_BVALID(O_S_AXI_BVALID), .I_S_AXI_BREADY(I_S_AXI_BREADY), .I_S_AXI_ARVALID(I_S_AXI_ARVALID),
  .O_S_AXI_ARREADY(O_S_AXI_ARREADY), .O_S_AXI_RDATA(O_S_AXI_RDATA), .O_S_AXI_RVALID(O_S_AXI_RVALID),
  .I_S_AXI_RREADY(I_S_AXI_RREADY)
);

/* File: tb/testbench.sv */
// self-checking bench for the baud and pulse block
// assumes the far-side model supplies the crystal clock and receiver pin
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_fail++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); end end
  logic clk = 0, rst_b = 0, tx = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, send = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, seed = 32'h4b5a_91e3;
  logic [3:0] wstrb = 4'h0;
  logic awr, wr, bv, arr, rv, irtx, rxdec, tick, bst, xtal, irrx;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int n_fail = 0, num_checks = 0;
  int pdv[4] = '{1, 3, 4, 13};
  initial forever #2 clk = ~clk;
  ir_serial_baud_and_pulse_ctrl DUT (
    .I_REF_CLK(clk), .I_RST_B(rst_b), .I_CRYSTAL_DERIVED_CLK(xtal), .I_TX_DATA(tx), .I_IR_RXD(irrx),
    .O_IR_TXD(irtx), .O_RXD_DEC(rxdec), .O_BAUD_TICK16(tick), .O_BIT_START(bst),
    .I_S_AXI_AWADDR(awaddr), .I_S_AXI_AWVALID(awv), .O_S_AXI_AWREADY(awr), .I_S_AXI_WDATA(wdata),
    .I_S_AXI_WSTRB(wstrb), .I_S_AXI_WVALID(wv), .O_S_AXI_WREADY(wr), .O_S_AXI_BRESP(bresp),
    .O_S_AXI_BVALID(bv), .I_S_AXI_BREADY(bready), .I_S_AXI_ARADDR(araddr), .I_S_AXI_ARVALID(arv),
    .O_S_AXI_ARREADY(arr), .O_S_AXI_RDATA(rdata), .O_S_AXI_RRESP(rresp), .O_S_AXI_RVALID(rv),
    .I_S_AXI_RREADY(rready)
  );
  ir_far_side u_far (.i_send(send), .o_xtal(xtal), .o_ir_rxd(irrx));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic [33:0] ex(input logic [1:0] r, input logic [7:0] b);
    return {r, 24'h00_0000, b};
  endfunction
  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // a used-up wait bound is a failure and ends the run
  task automatic tmo(input int i);
    if (i >= 4000) begin
      n_fail++;
      $display("CHECK FAILED wait bound exp 0 got 1");
      stop_test();
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    int i;
    logic ga, gw, gb;
    bq.push_back(e);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    {ga, gw, gb} = 3'h0;
    for (i = 0; i < 4000 && !gb; i++) begin
      @(posedge clk);
      if (!ga && awr === 1'b1) begin ga = 1; awv <= 1'b0; end
      if (!gw && wr === 1'b1) begin gw = 1; wv <= 1'b0; end
      if (bv === 1'b1) begin gb = 1; bready <= 1'b0; end
    end
    tmo(i);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [33:0] e);
    int i;
    logic ga, gr;
    rq.push_back(e);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    {ga, gr} = 2'h0;
    for (i = 0; i < 4000 && !gr; i++) begin
      @(posedge clk);
      if (!ga && arr === 1'b1) begin ga = 1; arv <= 1'b0; end
      if (rv === 1'b1) begin gr = 1; rready <= 1'b0; end
    end
    tmo(i);
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: pick = tick;
      1: pick = bst;
      2: pick = irtx;
      default: pick = !rxdec;
    endcase
  endfunction
  // cycles from one high sample of a strobe to the next
  task automatic per(input int k, output int n);
    int i;
    for (i = 0; i < 4000 && pick(k) !== 1'b1; i++) @(posedge clk);
    tmo(i);
    n = 0;
    do begin @(posedge clk); n++; end while (pick(k) !== 1'b1 && n < 4000);
    tmo(n);
  endtask
  // length of the next complete high stretch
  task automatic wid(input int k, output int n);
    int i;
    for (i = 0; i < 4000 && pick(k) !== 1'b0; i++) @(posedge clk);
    tmo(i);
    for (i = 0; i < 4000 && pick(k) !== 1'b1; i++) @(posedge clk);
    tmo(i);
    for (n = 0; n < 4000 && pick(k) === 1'b1; n++) @(posedge clk);
    tmo(n);
  endtask
  // scoreboard: each bus answer against the oldest note
  always @(posedge clk) begin
    logic [33:0] e;
    logic [1:0] eb;
    if (rv === 1'b1 && rready === 1'b1) begin
      e = rq.pop_front();
      `CHK("read", e, {rresp, rdata})
    end
    if (bv === 1'b1 && bready === 1'b1) begin
      eb = bq.pop_front();
      `CHK("bresp", eb, bresp)
    end
  end
  initial begin
    int k, n, ps;
    logic [7:0] lv;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    // reset values, then an unmapped read
    rd_reg(irbaud_pkg::RATE_SELECT_ADDR, ex(irbaud_pkg::RESP_OKAY, irbaud_pkg::RATE_SELECT_RESET));
    rd_reg(irbaud_pkg::IR_CONTROL_ADDR, ex(irbaud_pkg::RESP_OKAY, irbaud_pkg::IR_CONTROL_RESET));
    rd_reg(8'h0c, ex(irbaud_pkg::RESP_SLVERR, 8'h00));
    // random writes, each read back; unused bits must read zero
    for (k = 0; k < 8; k++) begin
      seed = xs(seed);
      lv = seed[7:0] & irbaud_pkg::RATE_SELECT_MASK;
      wr_reg(irbaud_pkg::RATE_SELECT_ADDR, seed, 4'hf, irbaud_pkg::RESP_OKAY);
      rd_reg(irbaud_pkg::RATE_SELECT_ADDR, ex(irbaud_pkg::RESP_OKAY, lv));
    end
    wr_reg(irbaud_pkg::RATE_SELECT_ADDR, 32'h0000_0077, 4'h0, irbaud_pkg::RESP_OKAY);
    rd_reg(irbaud_pkg::RATE_SELECT_ADDR, ex(irbaud_pkg::RESP_OKAY, lv));
    wr_reg(irbaud_pkg::STATUS_ADDR, 32'h0000_00ff, 4'hf, irbaud_pkg::RESP_SLVERR);
    wr_reg(8'h10, 32'h0000_00ff, 4'hf, irbaud_pkg::RESP_SLVERR);
    wr_reg(irbaud_pkg::IR_CONTROL_ADDR, seed, 4'hf, irbaud_pkg::RESP_OKAY);
    rd_reg(irbaud_pkg::IR_CONTROL_ADDR, ex(irbaud_pkg::RESP_OKAY, seed[7:0] & irbaud_pkg::IR_CONTROL_MASK));
    wr_reg(irbaud_pkg::IR_CONTROL_ADDR, 32'h0000_0000, 4'hf, irbaud_pkg::RESP_OKAY);
    // every prescaler and rate code on the bus clock; first gap may glitch
    for (k = 0; k < 32; k++) begin
      wr_reg(irbaud_pkg::RATE_SELECT_ADDR, {25'h0, 1'b1, k[4:3], 1'b0, k[2:0]}, 4'hf, irbaud_pkg::RESP_OKAY);
      per(0, n);
      per(0, n);
      `CHK("tick gap", pdv[k[4:3]] * (1 << k[2:0]), n)
    end
    wr_reg(irbaud_pkg::RATE_SELECT_ADDR, 32'h0000_0050, 4'hf, irbaud_pkg::RESP_OKAY);
    per(1, n);
    per(1, n);
    `CHK("bit gap", 16 * 3, n)
    // crystal source: 10 reference cycles per crystal period
    wr_reg(irbaud_pkg::RATE_SELECT_ADDR, 32'h0000_0010, 4'hf, irbaud_pkg::RESP_OKAY);
    per(0, n);
    per(0, n);
    `CHK("xtal tick gap", 3 * 10, n)
    // infrared on, four source ticks per sampling tick
    ps = 4;
    wr_reg(irbaud_pkg::RATE_SELECT_ADDR, 32'h0000_0060, 4'hf, irbaud_pkg::RESP_OKAY);
    for (k = 0; k < 4; k++) begin
      wr_reg(irbaud_pkg::IR_CONTROL_ADDR, {29'h0, k[1:0], 1'b1}, 4'hf, irbaud_pkg::RESP_OKAY);
      n = 0;
      repeat (80) begin @(posedge clk); n += (irtx === 1'b1); end
      `CHK("ones pulses", 0, n)
      tx <= 1'b0;
      wid(2, n);
      `CHK("pulse width", k == 0 ? 3 * ps : k == 1 ? ps : ps / 2, n)
      tx <= 1'b1;
    end
    send <= 1'b1;
    wid(3, n);
    send <= 1'b0;
    // decoder counts ticks, so start phase costs up to one tick
    `CHK("decode low", 1'b1, n > 15 * ps && n <= 16 * ps)
    // infrared off: pins pass straight through
    wr_reg(irbaud_pkg::IR_CONTROL_ADDR, 32'h0000_0000, 4'hf, irbaud_pkg::RESP_OKAY);
    repeat (40) begin
      @(posedge clk);
      seed = xs(seed);
      tx <= seed[0];
    end
    @(posedge clk);
    tx <= 1'b1;
    send <= 1'b1;
    wid(3, n);
    `CHK("raw rx low", 3, n)
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule
